// file: design/muting_monitor_block.sv
// Purpose: two-channel light curtain monitor with muting and bypass
// Assumes: all sensor and command inputs are asynchronous pins
// Notes:   one clock; timers advance on a 100 ms tick enable
module muting_monitor_block
   import muting_monitor_pkg::*;
#(
   parameter int unsigned TICK_LEN = TICK_CYCLES
) (
   input  wire logic              clock_in,
   input  wire logic              rst_n_in,
   input  wire logic              curtain_channel_one_in,
   input  wire logic              curtain_channel_two_in,
   input  wire logic              group_a_first_sensor_in,
   input  wire logic              group_a_second_sensor_in,
   input  wire logic              group_b_first_sensor_in,
   input  wire logic              group_b_second_sensor_in,
   input  wire logic              bypass_request_input_in,
   input  wire logic              acknowledge_input_in,
   input  wire logic              activation_in,
   input  wire logic              no_external_activation_in,
   input  wire logic [1:0]        restart_mode_in,
   input  wire logic [1:0]        sensor_mode_in,
   input  wire logic              power_up_check_in,
   input  wire logic [TIME_W-1:0] discrepancy_window_in,
   input  wire logic [TIME_W-1:0] bridging_limit_in,
   input  wire logic [TIME_W-1:0] sync_window_in,
   input  wire logic [TIME_W-1:0] bypass_limit_in,
   output logic                   safe_enable_contact_out,
   output logic                   muting_active_contact_out,
   output logic                   fault_contact_out,
   output logic [TIME_W-1:0]      discrepancy_elapsed_out,
   output logic [TIME_W-1:0]      bridging_elapsed_out,
   output logic [TIME_W-1:0]      sync_elapsed_out,
   output logic [TIME_W-1:0]      bypass_elapsed_out,
   output logic [15:0]            diagnostic_word_out
);
   // ************************************************************
   // reset release and input synchronisers
   // ************************************************************
   logic [1:0] rst_sync;
   logic       rst_n;
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) rst_sync <= 2'h0;
      else rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];
   localparam int unsigned NPIN = 9;
   logic [NPIN-1:0] pin_raw, pin_s1, pin_s2;
   assign pin_raw = {activation_in, acknowledge_input_in,
                     bypass_request_input_in,
                     group_b_second_sensor_in, group_b_first_sensor_in,
                     group_a_second_sensor_in, group_a_first_sensor_in,
                     curtain_channel_two_in, curtain_channel_one_in};
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) {pin_s2, pin_s1} <= '0;
      else {pin_s2, pin_s1} <= {pin_s1, pin_raw};
   end
   logic ch1, ch2, a1, a2, b1, b2, byp, ack, act;
   assign {act, ack, byp, b2, b1, a2, a1, ch2, ch1} = pin_s2;
   // ************************************************************
   // timebase tick
   // ************************************************************
   logic [31:0] tick_cnt, next_tick_cnt;
   logic        tick;
   always_comb begin
      tick = (tick_cnt == 32'(TICK_LEN - 1));
      next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
   end
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) tick_cnt <= 32'h0;
      else tick_cnt <= next_tick_cnt;
   end

   // timer helper: saturating count while running, else zero
   function automatic logic [TIME_W-1:0] step(
      input logic run, input logic tk, input logic [TIME_W-1:0] v);
      if (!run) return '0;
      if (tk && v != '1) return v + 1'b1;
      return v;
   endfunction
   // a limit of zero never expires
   function automatic logic expired(
      input logic [TIME_W-1:0] v, input logic [TIME_W-1:0] lim);
      return (lim != '0) && (v >= lim);
   endfunction
   // ************************************************************
   // conditions
   // ************************************************************
   logic enabled, both_clear, one_clear, four_mode;
   logic grp_a_on, grp_b_on, grp_mismatch, mute_cond;
   assign enabled    = no_external_activation_in || act;
   assign both_clear = ch1 && ch2;
   assign one_clear  = ch1 ^ ch2;
   assign four_mode  = sensor_mode_in[1];
   assign grp_a_on   = a1 && a2;
   assign grp_b_on   = b1 && b2;
   // two-sensor serial muting needs group a; four-sensor sequential accepts either group being active
   assign mute_cond  = sensor_mode_in[0] ?
                       (grp_a_on || (four_mode && grp_b_on)) :
                       (grp_a_on && (!four_mode || grp_b_on) ||
                        grp_a_on && four_mode);
   assign grp_mismatch = (a1 ^ a2) || (four_mode && (b1 ^ b2));

   // ************************************************************
   // state machine and timers
   // ************************************************************
   state_t            state, next_state;
   logic              muting, next_muting, bypassing, next_bypassing;
   logic              started, next_started;
   logic [15:0]       err_code, next_err_code;
   logic [TIME_W-1:0] t_dis, t_brg, t_syn, t_byp;
   logic [TIME_W-1:0] next_t_dis, next_t_brg, next_t_syn, next_t_byp;
   logic              dis_err, syn_err, brg_err;

   always_comb begin
      next_t_dis = step(one_clear, tick, t_dis);
      next_t_syn = step(grp_mismatch, tick, t_syn);
      next_t_brg = step(muting, tick, t_brg);
      // held once spent, so a request kept high cannot re-arm it
      next_t_byp = expired(t_byp, bypass_limit_in) ? t_byp :
                   step(byp && state == st_fault, tick, t_byp);
      dis_err = expired(t_dis, discrepancy_window_in);
      syn_err = expired(t_syn, sync_window_in);
      brg_err = expired(t_brg, bridging_limit_in);
      next_state     = state;
      next_started   = started;
      next_err_code  = err_code;
      // muting only from free, so a fault cannot re-arm it
      next_muting = (state == st_free) && mute_cond &&
                    !brg_err && !syn_err;
      // bypass only while muting sensors are engaged after a fault
      next_bypassing = byp && (state == st_fault) && mute_cond &&
                       !expired(t_byp, bypass_limit_in) &&
                       bypass_limit_in != '0;
      if (!enabled) begin
         next_state   = st_off;
         next_started = 1'b0;
      end else begin
         case (state)
            st_off: next_state = st_first;
            st_first: begin
               if (ch1 || ch2) next_state = st_second;
            end
            st_second: begin
               if (dis_err) begin
                  next_state    = st_fault;
                  next_err_code = DG_ERR_DISCREP;
               end else if (both_clear) begin
                  if (power_up_check_in && !started)
                     next_state = st_ack_hi; // startup check wants ack
                  else if (restart_mode_in == auto_restart_mode)
                     next_state = st_free;
                  else
                     next_state = st_ack_hi;
               end else if (!ch1 && !ch2)
                  next_state = st_first;
            end
            st_ack_hi: begin
               if (!both_clear) next_state = st_first;
               else if (ack) begin
                  // manual start releases on the press itself
                  if (restart_mode_in == manual_start_mode) begin
                     next_state   = st_free;
                     next_started = 1'b1;
                  end else next_state = st_ack_lo;
               end
            end
            st_ack_lo: begin
               if (!both_clear) next_state = st_first;
               else if (!ack) begin
                  next_state   = st_free;
                  next_started = 1'b1;
               end
            end
            st_free: begin
               if (syn_err || brg_err) begin
                  next_state    = st_fault;
                  next_err_code = syn_err ? DG_ERR_SYNC : DG_ERR_BRIDGE;
               end else if (!both_clear && !muting)
                  next_state = st_first;
            end
            st_fault: begin
               // acknowledged by dropping both channels once no sync error is present
               if (!ch1 && !ch2 && !syn_err) begin
                  next_state    = st_first;
                  next_err_code = DG_NO_ENABLE;
               end
            end
            default: next_state = st_off;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         state     <= st_off;
         muting    <= 1'b0;
         bypassing <= 1'b0;
         started   <= 1'b0;
         err_code  <= DG_NO_ENABLE;
         t_dis     <= '0;
         t_brg     <= '0;
         t_syn     <= '0;
         t_byp     <= '0;
      end else begin
         state     <= next_state;
         muting    <= next_muting;
         bypassing <= next_bypassing;
         started   <= next_started;
         err_code  <= next_err_code;
         t_dis     <= next_t_dis;
         t_brg     <= next_t_brg;
         t_syn     <= next_t_syn;
         t_byp     <= next_t_byp;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   logic [15:0] next_dg;
   always_comb begin
      case (state)
         st_off:    next_dg = DG_NO_ENABLE;
         st_first:  next_dg = DG_WAIT_FIRST;
         st_second: next_dg = DG_WAIT_SECOND;
         st_ack_hi: next_dg = (power_up_check_in && !started) ?
                              DG_STARTUP : DG_WAIT_ACK_HI;
         st_ack_lo: next_dg = DG_WAIT_ACK_LO;
         st_free:   next_dg = muting ? DG_MUTING : DG_FREE;
         st_fault:  next_dg = err_code;
         default:   next_dg = DG_NO_ENABLE;
      endcase
   end
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) diagnostic_word_out <= DG_NO_ENABLE;
      else diagnostic_word_out <= next_dg;
   end

   // safe when free with clear curtain, or bridged by muting/bypass
   assign safe_enable_contact_out = (state == st_free) &&
                                    (both_clear || muting) ||
                                    bypassing;
   assign muting_active_contact_out = muting || bypassing;
   assign fault_contact_out = (state == st_fault);
   assign discrepancy_elapsed_out = t_dis;
   assign bridging_elapsed_out    = t_brg;
   assign sync_elapsed_out        = t_syn;
   assign bypass_elapsed_out      = t_byp;

   // ************************************************************
   // checks
   // ************************************************************
   property p_fault_opens;
      @(posedge clock_in) disable iff (!rst_n)
      fault_contact_out |-> !safe_enable_contact_out || bypassing;
   endproperty
   a_fault_opens: assert property (p_fault_opens)
      else $error("enable closed during fault");
   property p_disabled_off;
      @(posedge clock_in) disable iff (!rst_n)
      !enabled |=> state == st_off;
   endproperty
   a_disabled_off: assert property (p_disabled_off)
      else $error("block active without activation");
   property p_dis_err;
      @(posedge clock_in) disable iff (!rst_n)
      state == st_second && dis_err && enabled |=> fault_contact_out;
   endproperty
   a_dis_err: assert property (p_dis_err)
      else $error("discrepancy expiry missed");
   property p_sync_err;
      @(posedge clock_in) disable iff (!rst_n)
      state == st_free && syn_err && enabled |=> fault_contact_out;
   endproperty
   a_sync_err: assert property (p_sync_err)
      else $error("sync expiry missed");
   property p_off_never;
      @(posedge clock_in) disable iff (!rst_n)
      sync_window_in == '0 |-> !syn_err;
   endproperty
   a_off_never: assert property (p_off_never)
      else $error("disabled timer expired");
   property p_mute_contact;
      @(posedge clock_in) disable iff (!rst_n)
      muting |-> muting_active_contact_out;
   endproperty
   a_mute_contact: assert property (p_mute_contact)
      else $error("muting contact open");
   sequence s_ack_press;
      state == st_ack_hi && ack && both_clear && enabled &&
      restart_mode_in == controlled_start_mode;
   endsequence
   property p_ack;
      @(posedge clock_in) disable iff (!rst_n)
      s_ack_press |=> state == st_ack_lo;
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledge edge not followed");
   property p_safe_needs_free;
      @(posedge clock_in) disable iff (!rst_n)
      safe_enable_contact_out |-> state == st_free || bypassing;
   endproperty
   a_safe_needs_free: assert property (p_safe_needs_free)
      else $error("enable outside safe state");
   property p_timer_grows;
      @(posedge clock_in) disable iff (!rst_n)
      one_clear && tick && t_dis != '1 |=> t_dis == $past(t_dis) + 1'b1;
   endproperty
   a_timer_grows: assert property (p_timer_grows)
      else $error("discrepancy timer stalled");
endmodule

// file: design/muting_monitor_pkg.sv
// Purpose: constants for the light curtain muting monitor
// Assumes: 100 MHz clock, 100 ms timebase tick
// Notes:   times held in tenths of a second
package muting_monitor_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned TICK_MS         = 100;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TIME_W          = 13;
   // times in ticks of 0.1 s; zero means off
   localparam logic [12:0] DISCREP_DEFAULT = 13'h001e;
   localparam logic [12:0] BRIDGE_DEFAULT  = 13'h0000;
   localparam logic [12:0] SYNC_DEFAULT    = 13'h0028;
   localparam logic [12:0] BYPASS_DEFAULT  = 13'h0000;
   localparam logic [15:0] DG_NO_ENABLE    = 16'h0000;
   localparam logic [15:0] DG_WAIT_FIRST   = 16'h2001;
   localparam logic [15:0] DG_WAIT_SECOND  = 16'h2002;
   localparam logic [15:0] DG_WAIT_ACK_HI  = 16'h2003;
   localparam logic [15:0] DG_WAIT_ACK_LO  = 16'h2004;
   localparam logic [15:0] DG_STARTUP      = 16'h200e;
   localparam logic [15:0] DG_FREE         = 16'h8005;
   localparam logic [15:0] DG_MUTING       = 16'h8006;
   localparam logic [15:0] DG_ERR_DISCREP  = 16'hf001;
   localparam logic [15:0] DG_ERR_SYNC     = 16'hf003;
   localparam logic [15:0] DG_ERR_BRIDGE   = 16'hf004;
   typedef enum logic [1:0] {
      auto_restart_mode     = 2'h0,
      manual_start_mode     = 2'h1, // default
      controlled_start_mode = 2'h2
   } restart_t;
   typedef enum logic [1:0] {
      two_sensor_parallel   = 2'h0, // default
      two_sensor_serial     = 2'h1,
      four_sensor_parallel  = 2'h2,
      four_sensor_sequential = 2'h3
   } sensors_t;
   typedef enum logic [6:0] {
      st_off     = 7'h01,
      st_first   = 7'h02,
      st_second  = 7'h04,
      st_ack_hi  = 7'h08,
      st_ack_lo  = 7'h10,
      st_free    = 7'h20,
      st_fault   = 7'h40
   } state_t;
endpackage

// file: tb/curtain_sensor_model.sv
// Purpose: far-side model of the light curtain and the muting sensors
// Assumes: commands come from the bench shortly after a clock edge
// Notes:   channels are plain levels, no test pulses
module curtain_sensor_model (
   input  wire logic       clear_in,
   input  wire logic       one_only_in,
   input  wire logic [3:0] sensors_in,
   output logic            ch_one_out,
   output logic            ch_two_out,
   output logic [3:0]      sensors_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // *****************************************
   // curtain outputs
   // *****************************************
   // one_only leaves channel two open, a broken pair
   assign ch_one_out  = clear_in | one_only_in;
   assign ch_two_out  = clear_in & ~one_only_in;
   // sensors order: a first, a second, b first, b second
   assign sensors_out = sensors_in;
endmodule

// file: tb/muting_monitor_block_tb_top.sv
// Purpose: self-checking bench of the muting monitor
// Assumes: tick shortened to 4 cycles, windows set in ticks
// Notes:   waits on the diagnostic word under a bounded count
`define CHK(got, exp) check_val(16'(got), 16'(exp))
module muting_monitor_block_tb_top;
   import muting_monitor_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TL = 4;
   logic              clock_in, rst_n, clear, one_only, bypass, ack;
   logic              act, no_ext, pwr_chk;
   logic [3:0]        sens_cmd, sens;
   logic [1:0]        rmode, smode;
   logic [TIME_W-1:0] dwin, blim, swin, ylim;
   logic              ch1, ch2, safe, mute, fault;
   logic [TIME_W-1:0] d_el, b_el, s_el, y_el;
   logic [15:0]       diag;
   int                fail_count, cmp_count, cyc;
   muting_monitor_block #(.TICK_LEN(TL)) muting_monitor_block_i (
      .clock_in(clock_in), .rst_n_in(rst_n),
      .curtain_channel_one_in(ch1), .curtain_channel_two_in(ch2),
      .group_a_first_sensor_in(sens[0]), .group_a_second_sensor_in(sens[1]),
      .group_b_first_sensor_in(sens[2]), .group_b_second_sensor_in(sens[3]),
      .bypass_request_input_in(bypass), .acknowledge_input_in(ack),
      .activation_in(act), .no_external_activation_in(no_ext),
      .restart_mode_in(rmode), .sensor_mode_in(smode),
      .power_up_check_in(pwr_chk), .discrepancy_window_in(dwin),
      .bridging_limit_in(blim), .sync_window_in(swin),
      .bypass_limit_in(ylim), .safe_enable_contact_out(safe),
      .muting_active_contact_out(mute), .fault_contact_out(fault),
      .discrepancy_elapsed_out(d_el), .bridging_elapsed_out(b_el),
      .sync_elapsed_out(s_el), .bypass_elapsed_out(y_el),
      .diagnostic_word_out(diag));
   curtain_sensor_model curtain_sensor_model_i (
      .clear_in(clear), .one_only_in(one_only), .sensors_in(sens_cmd),
      .ch_one_out(ch1), .ch_two_out(ch2), .sensors_out(sens));
   // *****************************************
   // clock and timeout
   // *****************************************
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // whole run is well under 3000 cycles
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end
   // *****************************************
   // tasks
   // *****************************************
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      step(12);
      rst_n = 1'b1;
   endtask
   task automatic wait_diag(input logic [15:0] exp, input int lim);
      int i;
      for (i = 0; i < lim && diag !== exp; i++) step(1);
      `CHK(diag, exp);
   endtask
   task automatic test_end(input string name);
      $display("test %s done", name);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // clear curtain, then go to free per restart mode
   task automatic start_free(input logic [1:0] m);
      clear = 1'b1;
      if (m != 2'h0) begin
         wait_diag(DG_WAIT_ACK_HI, 60);
         ack = 1'b1;
         if (m == 2'h2) wait_diag(DG_WAIT_ACK_LO, 60);
         step(2);
         ack = 1'b0;
      end
      wait_diag(DG_FREE, 60);
      `CHK(safe, 1'b1);
   endtask
   task automatic drop_fault();
      sens_cmd = 4'h0;
      clear = 1'b0;
      one_only = 1'b0;
      wait_diag(DG_WAIT_FIRST, 60);
      `CHK(fault, 1'b0);
   endtask
   // *****************************************
   // main sequence
   // *****************************************
   initial begin
      cyc = 0; fail_count = 0; cmp_count = 0;
      rst_n = 1'b0; clear = 1'b0; one_only = 1'b0; sens_cmd = 4'h0;
      bypass = 1'b0; ack = 1'b0; act = 1'b0; no_ext = 1'b1;
      pwr_chk = 1'b0; rmode = 2'h1; smode = 2'h0;
      dwin = 13'h0005; blim = 13'h0006; swin = 13'h0005; ylim = 13'h0000;
      step(1);
      `CHK(diag, DG_NO_ENABLE);
      `CHK(d_el | b_el | s_el | y_el, 13'h0000);
      do_reset();
      wait_diag(DG_WAIT_FIRST, 20);
      `CHK({safe, mute, fault}, 3'h0);
      test_end("reset");
      start_free(2'h1);
      clear = 1'b0;
      step(6);
      `CHK(safe, 1'b0);
      test_end("manual start");
      one_only = 1'b1;
      wait_diag(DG_ERR_DISCREP, 20 + 8 * TL);
      `CHK({safe, fault}, 2'h1);
      drop_fault();
      test_end("discrepancy");
      rmode = 2'h2;
      start_free(2'h2);
      sens_cmd = 4'h3;
      wait_diag(DG_MUTING, 20);
      `CHK(mute, 1'b1);
      clear = 1'b0;
      step(8);
      `CHK(safe, 1'b1);
      clear = 1'b1;
      wait_diag(DG_ERR_BRIDGE, 20 + 8 * TL);
      `CHK({safe, fault}, 2'h1);
      step(12);
      `CHK(mute, 1'b0);
      drop_fault();
      `CHK(mute, 1'b0);
      test_end("bridging limit");
      rmode = 2'h0;
      start_free(2'h0);
      sens_cmd = 4'h1;
      wait_diag(DG_ERR_SYNC, 20 + 8 * TL);
      `CHK({safe, fault}, 2'h1);
      test_end("sync window");
      ylim = 13'h0004;
      sens_cmd = 4'h3;
      bypass = 1'b1;
      step(6);
      `CHK({safe, mute}, 2'h3);
      step(24);
      `CHK(safe, 1'b0);
      `CHK(y_el, 13'h0004);
      bypass = 1'b0;
      drop_fault();
      test_end("bypass");
      smode = 2'h2;
      start_free(2'h0);
      sens_cmd = 4'h7;
      wait_diag(DG_ERR_SYNC, 20 + 8 * TL);
      drop_fault();
      smode = 2'h3;
      start_free(2'h0);
      sens_cmd = 4'hc;
      wait_diag(DG_MUTING, 20);
      sens_cmd = 4'h0;
      wait_diag(DG_FREE, 20);
      `CHK(mute, 1'b0);
      test_end("sensor modes");
      no_ext = 1'b0;
      do_reset();
      step(30);
      `CHK(diag, DG_NO_ENABLE);
      clear = 1'b1;
      step(10);
      `CHK(safe, 1'b0);
      clear = 1'b0;
      act = 1'b1;
      wait_diag(DG_WAIT_FIRST, 20);
      test_end("activation");
      pwr_chk = 1'b1;
      clear = 1'b1;
      wait_diag(DG_STARTUP, 60);
      ack = 1'b1;
      wait_diag(DG_WAIT_ACK_LO, 60);
      ack = 1'b0;
      wait_diag(DG_FREE, 60);
      `CHK(safe, 1'b1);
      test_end("startup check");
      end_sim();
   end
endmodule
